// ---- rtl/lbs_cfg.svh ----
// lbs_cfg.svh: register indices, field positions, reset values and timing for the
// led behaviour selector. assumes a 200 MHz system clock and APB byte addressing.
`ifndef LBS_CFG_SVH
`define LBS_CFG_SVH
// register indices; byte address is four times the index
`define LBS_IDX_SEL_A 8'h81
`define LBS_IDX_SEL_B 8'h82
`define LBS_IDX_SEL_C 8'h83
`define LBS_IDX_DRIVE 8'h90
`define LBS_IDX_LINK 8'h91
`define LBS_IDX_POL 8'h92
`define LBS_IDX_DIRIN 8'h93
`define LBS_IDX_CFG 8'h94
`define LBS_IDX_PER 8'h95
`define LBS_IDX_STAT 8'h96
`define LBS_IDX_LSB 2
`define LBS_IDX_MSB 9
// behaviour codes
`define LBS_MODE_DIRECT 2'h0
`define LBS_MODE_PULSE1 2'h1
`define LBS_MODE_PULSE2 2'h2
`define LBS_MODE_BREATHE 2'h3
// config register bit positions
`define LBS_CFG_PWR 0
`define LBS_CFG_SLEEP 1
`define LBS_CFG_DEEP_LOW_POWER_BIT 2
`define LBS_CFG_EDGE 3
`define LBS_CFG_CNT1_LSB 4
`define LBS_CFG_CNT2_LSB 7
// period register field positions
`define LBS_PER_P1_LSB 0
`define LBS_PER_P2_LSB 8
`define LBS_PER_BR_LSB 16
// reset values
`define LBS_SEL_RST 8'h00
`define LBS_VEC_RST 11'h000
`define LBS_CNT_RST 3'h4
`define LBS_P1_RST 7'h20
`define LBS_P2_RST 7'h14
`define LBS_BR_RST 7'h5D
`define LBS_DUTY_MIN 8'h00
`define LBS_DUTY_MAX 8'hFF
// timing: a period step is split into ramp sub-ticks
`define LBS_STEP_MS 32
`define LBS_RAMP_STEPS 512
`define LBS_CLK_NS 5
`endif

// ---- rtl/lbs_pkg.sv ----
// lbs_pkg: types shared by the led behaviour selector.
// assumes lbs_cfg.svh supplies all numeric constants.
package lbs_pkg;
	// per-channel sequencing state
	typedef enum {ST_IDLE, ST_RUN, ST_P1, ST_TAIL} lbs_state_e;
	// one channel's running context
	typedef struct packed {
		logic [1:0] mode;
		logic [7:0] duty;
		logic up;
		logic [6:0] pre;
		logic [2:0] cnt;
	} lbs_chan_s;
	// apb request group from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lbs_apb_req_s;
endpackage : lbs_pkg

// ---- rtl/lbs_top.sv ----
// lbs_top: eleven-channel led behaviour selector with an apb register file.
// assumes touch status arrives as levels from logic on SYS_CLK, apb master on SYS_CLK.
//
// Overview of operation
// - two-bit behaviour field per channel
// - input-configured channel ignores its field
// - linked channel follows sensor touch/release
// - unlinked channel: drive bit set/clear
// - start and stop triggers per mode
// - idle output level from polarity
// - pulse one ignores drive bit until done
// - link switch: direct/breathe follow, pulses finish
// - inactive new source acts as release
// - first register holds channels four to one
// - second register holds channels eight to five
// - channel eleven sleep field when asleep with the indicator on
// - channel eleven awake field otherwise
// - third register low fields: channels ten, nine
// - direct drives active on start, idle on stop
// - pulse one: counted pulses, no stop
// - pulse two: continuous, counted tail, then minimum
// - breathe ramps minimum to maximum and back
// - direct runs at maximum pwm rate
// - edge select picks pulse one start edge
// - count field zero means one pulse
// - period steps of one unit, zero as one
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "lbs_cfg.svh"
module lbs_top #(
	parameter int NCH = 11,
	parameter int SUBTICK_CYC = (`LBS_STEP_MS * 1000000 / `LBS_RAMP_STEPS) / `LBS_CLK_NS,
	parameter logic [10:0] LINK_MASK = 11'h37F
) (
	input wire logic SYS_CLK, // system clock
	input wire logic SYS_RST, // synchronous reset, active high
	input wire lbs_pkg::lbs_apb_req_s APB_REQ, // apb request group
	output logic [31:0] PRDATA, // apb read data
	output logic PREADY, // apb ready
	output logic PSLVERR, // apb error on unmapped address
	input wire logic [NCH-1:0] TOUCH_IN, // touch levels, ch9/ch10 group down/up
	output logic [NCH-1:0] LED_OUT, // led pin levels
	output logic [NCH-1:0] LED_OE_N // pin drive enable, low while driven
);
	// elaboration checks: field packing is fixed at eleven channels
	if (NCH != 11) begin : g_nch_chk
		$error("lbs_top supports exactly eleven channels");
	end
	if (SUBTICK_CYC < 1) begin : g_tick_chk
		$error("SUBTICK_CYC must be at least one");
	end
	// register file
	logic [7:0] sel_a_r, sel_b_r, sel_c_r;
	logic [NCH-1:0] drive_r, link_r, pol_r, dirin_r;
	logic [9:0] cfg_r;
	logic [6:0] p1_r, p2_r, br_r;
	logic [31:0] prdata_r;
	// apb decode
	wire [7:0] idx = APB_REQ.paddr[`LBS_IDX_MSB:`LBS_IDX_LSB];
	wire aligned = (APB_REQ.paddr[1:0] == 2'h0) && (APB_REQ.paddr[11:10] == 2'h0);
	wire setup = APB_REQ.psel && !APB_REQ.penable;
	wire access = APB_REQ.psel && APB_REQ.penable;
	wire wr = access && APB_REQ.pwrite;
	logic mapped;
	logic [31:0] rd_mux;
	// per-channel state
	lbs_pkg::lbs_state_e st_r [NCH];
	lbs_pkg::lbs_state_e st_nxt [NCH];
	lbs_pkg::lbs_chan_s ch_r [NCH];
	lbs_pkg::lbs_chan_s ch_nxt [NCH];
	logic [NCH-1:0] src_d_r;
	logic [NCH-1:0] active;
	logic [NCH-1:0] lit;
	logic [NCH-1:0] out_r;
	logic [7:0] pwm_r;
	logic [31:0] sub_r;
	// zero period behaves as one step
	function automatic logic [6:0] per_min1(input logic [6:0] p);
		per_min1 = (p == 7'h00) ? 7'h01 : p;
	endfunction : per_min1
	// pwm compare; full scale forces a steady on level
	function automatic logic pwm_on(input logic [7:0] duty, input logic [7:0] cnt);
		pwm_on = (duty == `LBS_DUTY_MAX) || (duty > cnt);
	endfunction : pwm_on
	// read selection and map check
	always_comb begin
		mapped = aligned;
		rd_mux = 32'h0000_0000;
		if (idx == `LBS_IDX_SEL_A) begin
			rd_mux = {24'h000000, sel_a_r};
		end else if (idx == `LBS_IDX_SEL_B) begin
			rd_mux = {24'h000000, sel_b_r};
		end else if (idx == `LBS_IDX_SEL_C) begin
			rd_mux = {24'h000000, sel_c_r};
		end else if (idx == `LBS_IDX_DRIVE) begin
			rd_mux = {21'h000000, drive_r};
		end else if (idx == `LBS_IDX_LINK) begin
			rd_mux = {21'h000000, link_r};
		end else if (idx == `LBS_IDX_POL) begin
			rd_mux = {21'h000000, pol_r};
		end else if (idx == `LBS_IDX_DIRIN) begin
			rd_mux = {21'h000000, dirin_r};
		end else if (idx == `LBS_IDX_CFG) begin
			rd_mux = {22'h000000, cfg_r};
		end else if (idx == `LBS_IDX_PER) begin
			rd_mux = {9'h000, br_r, 1'b0, p2_r, 1'b0, p1_r};
		end else if (idx == `LBS_IDX_STAT) begin
			rd_mux = {5'h00, out_r, 5'h00, active};
		end else begin
			mapped = 1'b0;
		end
	end
	// zero wait states; errors only in the access phase
	assign PREADY = 1'b1;
	assign PSLVERR = access && !mapped;
	assign PRDATA = prdata_r;
	// read data is captured in the setup cycle so it is steady for the access
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup && !APB_REQ.pwrite) begin
			prdata_r <= mapped ? rd_mux : 32'h0000_0000;
		end
	end
	// register writes take effect at the access edge only
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sel_a_r <= `LBS_SEL_RST;
			sel_b_r <= `LBS_SEL_RST;
			sel_c_r <= `LBS_SEL_RST;
			drive_r <= `LBS_VEC_RST;
			link_r <= `LBS_VEC_RST;
			pol_r <= `LBS_VEC_RST;
			dirin_r <= `LBS_VEC_RST;
			cfg_r <= {`LBS_CNT_RST, `LBS_CNT_RST, 4'h0};
			p1_r <= `LBS_P1_RST;
			p2_r <= `LBS_P2_RST;
			br_r <= `LBS_BR_RST;
		end else if (wr && aligned) begin
			if (idx == `LBS_IDX_SEL_A) begin
				sel_a_r <= APB_REQ.pwdata[7:0];
			end else if (idx == `LBS_IDX_SEL_B) begin
				sel_b_r <= APB_REQ.pwdata[7:0];
			end else if (idx == `LBS_IDX_SEL_C) begin
				sel_c_r <= APB_REQ.pwdata[7:0];
			end else if (idx == `LBS_IDX_DRIVE) begin
				drive_r <= APB_REQ.pwdata[NCH-1:0];
			end else if (idx == `LBS_IDX_LINK) begin
				link_r <= APB_REQ.pwdata[NCH-1:0] & LINK_MASK;
			end else if (idx == `LBS_IDX_POL) begin
				pol_r <= APB_REQ.pwdata[NCH-1:0];
			end else if (idx == `LBS_IDX_DIRIN) begin
				dirin_r <= APB_REQ.pwdata[NCH-1:0];
			end else if (idx == `LBS_IDX_CFG) begin
				cfg_r <= APB_REQ.pwdata[9:0];
			end else if (idx == `LBS_IDX_PER) begin
				p1_r <= APB_REQ.pwdata[`LBS_PER_P1_LSB +: 7];
				p2_r <= APB_REQ.pwdata[`LBS_PER_P2_LSB +: 7];
				br_r <= APB_REQ.pwdata[`LBS_PER_BR_LSB +: 7];
			end
		end
	end
	// channel eleven picks its sleep field only with the indicator on and asleep
	wire asleep = cfg_r[`LBS_CFG_SLEEP] || cfg_r[`LBS_CFG_DEEP_LOW_POWER_BIT];
	wire use_alt = cfg_r[`LBS_CFG_PWR] && asleep;
	wire [1:0] ch11_field = use_alt ? sel_c_r[7:6] : sel_c_r[5:4];
	// packed fields, two bits per channel, channel one lowest
	wire [2*NCH-1:0] fld = {ch11_field, sel_c_r[3:0], sel_b_r, sel_a_r};
	// trigger source: sensor when linked, drive bit otherwise
	wire [NCH-1:0] lnk = link_r & LINK_MASK;
	wire [NCH-1:0] src = (lnk & TOUCH_IN) | (~lnk & drive_r);
	// a link switch onto a low source shows as a fall, i.e. a release
	wire [NCH-1:0] rise = src & ~src_d_r;
	wire [NCH-1:0] fall = ~src & src_d_r;
	wire edge_sel = cfg_r[`LBS_CFG_EDGE];
	wire [2:0] cnt1 = cfg_r[`LBS_CFG_CNT1_LSB +: 3];
	wire [2:0] cnt2 = cfg_r[`LBS_CFG_CNT2_LSB +: 3];
	wire tick = (sub_r == SUBTICK_CYC - 1);
	// group start on one of nine/ten forces the other off; nine wins a tie
	logic [NCH-1:0] grp_start;
	logic [NCH-1:0] force_off;
	always_comb begin
		grp_start = '0;
		force_off = '0;
		for (int i = 8; i < 10; i++) begin
			grp_start[i] = lnk[i] && rise[i] && (st_r[i] == lbs_pkg::ST_IDLE) && !dirin_r[i];
		end
		force_off[9] = grp_start[8];
		force_off[8] = grp_start[9] && !grp_start[8];
	end
	// sub-tick divider and pwm counter
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sub_r <= 32'h0000_0000;
			pwm_r <= 8'h00;
		end else begin
			sub_r <= tick ? 32'h0000_0000 : sub_r + 32'h0000_0001;
			pwm_r <= pwm_r + 8'h01; // free running: highest pwm rate
		end
	end
	// per-channel sequencing
	always_comb begin
		logic [6:0] per;
		logic pend;
		logic [1:0] live;
		per = 7'h01;
		pend = 1'b0;
		live = `LBS_MODE_DIRECT;
		for (int i = 0; i < NCH; i++) begin
			st_nxt[i] = st_r[i];
			ch_nxt[i] = ch_r[i];
			live = fld[2*i +: 2];
			// period of the behaviour running on this channel
			if (ch_r[i].mode == `LBS_MODE_PULSE1) begin
				per = per_min1(p1_r);
			end else if (ch_r[i].mode == `LBS_MODE_PULSE2) begin
				per = per_min1(p2_r);
			end else begin
				per = per_min1(br_r);
			end
			// triangle ramp: min to max to min per pulse
			pend = 1'b0;
			if (tick && (st_r[i] != lbs_pkg::ST_IDLE) && (ch_r[i].mode != `LBS_MODE_DIRECT)) begin
				if (7'(ch_r[i].pre + 7'h01) >= per) begin
					ch_nxt[i].pre = 7'h00;
					if (ch_r[i].up) begin
						if (ch_r[i].duty == `LBS_DUTY_MAX) begin
							ch_nxt[i].up = 1'b0;
						end else begin
							ch_nxt[i].duty = 8'(ch_r[i].duty + 8'h01);
						end
					end else if (ch_r[i].duty == `LBS_DUTY_MIN) begin
						ch_nxt[i].up = 1'b1;
						pend = 1'b1;
					end else begin
						ch_nxt[i].duty = 8'(ch_r[i].duty - 8'h01);
					end
				end else begin
					ch_nxt[i].pre = 7'(ch_r[i].pre + 7'h01);
				end
			end
			case (st_r[i])
				lbs_pkg::ST_IDLE: begin
					ch_nxt[i].duty = `LBS_DUTY_MIN;
					ch_nxt[i].up = 1'b1;
					ch_nxt[i].pre = 7'h00;
					ch_nxt[i].cnt = 3'h0;
					ch_nxt[i].mode = live; // mode latched only when idle
					if (live == `LBS_MODE_PULSE1) begin
						if (edge_sel ? fall[i] : rise[i]) begin
							st_nxt[i] = lbs_pkg::ST_P1;
						end
					end else if (rise[i]) begin
						st_nxt[i] = lbs_pkg::ST_RUN;
					end
				end
				lbs_pkg::ST_RUN: begin
					if (fall[i]) begin
						if (ch_r[i].mode == `LBS_MODE_PULSE2) begin
							st_nxt[i] = lbs_pkg::ST_TAIL;
							ch_nxt[i].cnt = 3'h0;
						end else begin
							st_nxt[i] = lbs_pkg::ST_IDLE;
						end
					end
				end
				lbs_pkg::ST_P1: begin
					// source edges are ignored and not remembered here
					if (pend) begin
						if (ch_r[i].cnt == cnt1) begin
							st_nxt[i] = lbs_pkg::ST_IDLE;
						end else begin
							ch_nxt[i].cnt = 3'(ch_r[i].cnt + 3'h1);
						end
					end
				end
				lbs_pkg::ST_TAIL: begin
					if (pend) begin
						if (ch_r[i].cnt == cnt2) begin
							st_nxt[i] = lbs_pkg::ST_IDLE;
						end else begin
							ch_nxt[i].cnt = 3'(ch_r[i].cnt + 3'h1);
						end
					end
				end
				default: begin
					st_nxt[i] = lbs_pkg::ST_IDLE;
				end
			endcase
			// input pins and the group interlock override everything
			if (dirin_r[i] || force_off[i]) begin
				st_nxt[i] = lbs_pkg::ST_IDLE;
			end
		end
	end
	// lit level: direct is steady on, ramped modes use the pwm compare
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			active[i] = (st_r[i] != lbs_pkg::ST_IDLE);
			if (!active[i]) begin
				lit[i] = 1'b0;
			end else if (ch_r[i].mode == `LBS_MODE_DIRECT) begin
				lit[i] = 1'b1;
			end else begin
				lit[i] = pwm_on(ch_r[i].duty, pwm_r);
			end
		end
	end
	// channel registers
	always_ff @(posedge SYS_CLK) begin
		for (int i = 0; i < NCH; i++) begin
			if (SYS_RST) begin
				st_r[i] <= lbs_pkg::ST_IDLE;
				ch_r[i] <= '0;
			end else begin
				st_r[i] <= st_nxt[i];
				ch_r[i] <= ch_nxt[i];
			end
		end
	end
	// previous source level and pin register; idle level equals polarity bit
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			src_d_r <= '0;
			out_r <= '0;
		end else begin
			src_d_r <= src;
			out_r <= lit ^ pol_r;
		end
	end
	assign LED_OUT = out_r;
	assign LED_OE_N = dirin_r;
	// checks; the pin is registered, so it shows the polarity of the cycle before
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_wr_a;
		wr && aligned && (idx == `LBS_IDX_SEL_A);
	endsequence
	sequence s_direct_start;
		(st_r[0] == lbs_pkg::ST_IDLE) && (fld[1:0] == `LBS_MODE_DIRECT) && rise[0] && !dirin_r[0];
	endsequence
	property p_sel_a_store;
		s_wr_a |=> (sel_a_r == $past(APB_REQ.pwdata[7:0])) && (fld[7:0] == sel_a_r);
	endproperty
	a_sel_a_store: assert property (p_sel_a_store) else $error("mode field a not stored");
	property p_direct_on;
		s_direct_start |=> (st_r[0] == lbs_pkg::ST_RUN) ##1 (out_r[0] == !$past(pol_r[0]));
	endproperty
	a_direct_on: assert property (p_direct_on) else $error("direct start not driven");
	property p_idle_level;
		(st_r[0] == lbs_pkg::ST_IDLE) |=> (out_r[0] == $past(pol_r[0]));
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle level not polarity");
	property p_input_idle;
		dirin_r[0] |=> (st_r[0] == lbs_pkg::ST_IDLE);
	endproperty
	a_input_idle: assert property (p_input_idle) else $error("input channel not idle");
	property p_p1_hold;
		(st_r[3] == lbs_pkg::ST_P1) && !tick && !dirin_r[3] |=> (st_r[3] == lbs_pkg::ST_P1);
	endproperty
	a_p1_hold: assert property (p_p1_hold) else $error("pulse one left early");
	property p_p2_tail;
		(st_r[4] == lbs_pkg::ST_RUN) && (ch_r[4].mode == `LBS_MODE_PULSE2) && fall[4]
			&& !dirin_r[4] |=> (st_r[4] == lbs_pkg::ST_TAIL) && (ch_r[4].cnt == 3'h0);
	endproperty
	a_p2_tail: assert property (p_p2_tail) else $error("pulse two tail missing");
	property p_release_on_link;
		(st_r[2] == lbs_pkg::ST_RUN) && (ch_r[2].mode == `LBS_MODE_DIRECT) && src_d_r[2]
			&& !src[2] |=> (st_r[2] == lbs_pkg::ST_IDLE);
	endproperty
	a_release_on_link: assert property (p_release_on_link) else $error("release not taken");
	property p_group_excl;
		grp_start[8] |=> (st_r[9] == lbs_pkg::ST_IDLE);
	endproperty
	a_group_excl: assert property (p_group_excl) else $error("ch10 not forced off");
	property p_group_excl_up;
		grp_start[9] && !grp_start[8] |=> (st_r[8] == lbs_pkg::ST_IDLE);
	endproperty
	a_group_excl_up: assert property (p_group_excl_up) else $error("ch9 not forced off");
	// the mode latched by an idle channel eleven shows which field was chosen
	property p_ch11_alt;
		(st_r[10] == lbs_pkg::ST_IDLE) && cfg_r[`LBS_CFG_PWR]
			&& (cfg_r[`LBS_CFG_SLEEP] || cfg_r[`LBS_CFG_DEEP_LOW_POWER_BIT])
			|=> (ch_r[10].mode == $past(sel_c_r[7:6]));
	endproperty
	a_ch11_alt: assert property (p_ch11_alt) else $error("ch11 sleep field unused");
	property p_ch11_awake;
		(st_r[10] == lbs_pkg::ST_IDLE) && !(cfg_r[`LBS_CFG_PWR]
			&& (cfg_r[`LBS_CFG_SLEEP] || cfg_r[`LBS_CFG_DEEP_LOW_POWER_BIT]))
			|=> (ch_r[10].mode == $past(sel_c_r[5:4]));
	endproperty
	a_ch11_awake: assert property (p_ch11_awake) else $error("ch11 awake field unused");
endmodule : lbs_top

`default_nettype wire

// ---- tb/lbs_touch_model.sv ----
// lbs_touch_model: touch sensor front end facing the led behaviour selector.
// assumes the bench asks for presses on SYS_CLK; detections come out as levels.
`timescale 1ns/1ps
`default_nettype none

module lbs_touch_model (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [10:0] press, // finger present per channel, from the bench
	output logic [10:0] touch // detected touch level per channel
);
	// detection lags the finger by one edge, as a real detector never answers at once
	always_ff @(posedge clk) begin
		if (rst) begin
			touch <= 11'h000;
		end else begin
			touch <= press;
		end
	end
endmodule : lbs_touch_model

`default_nettype wire

// ---- tb/lbs_top_bench.sv ----
// lbs_top_bench: apb-driven self-checking bench for the led behaviour selector.
// assumes lbs_top, lbs_pkg and lbs_touch_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end

module lbs_top_bench;
	localparam logic [11:0] SELA = 12'h204;
	localparam logic [11:0] SELB = 12'h208;
	localparam logic [11:0] SELC = 12'h20C;
	localparam logic [11:0] DRV = 12'h240;
	localparam logic [11:0] LNK = 12'h244;
	localparam logic [11:0] POL = 12'h248;
	localparam logic [11:0] DIR = 12'h24C;
	localparam logic [11:0] CFG = 12'h250;
	localparam logic [11:0] STAT = 12'h258;
	logic clk = 1'b0;
	logic rst = 1'b1;
	lbs_pkg::lbs_apb_req_s apb = '0;
	logic [10:0] press = 11'h000;
	logic [10:0] touch;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [10:0] led;
	logic [10:0] oe_n;
	logic [31:0] rd;
	logic err;
	int fails = 0;
	int checked = 0;
	int tg;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	lbs_top #(.SUBTICK_CYC(2)) i_lbs_top (.SYS_CLK(clk), .SYS_RST(rst), .APB_REQ(apb),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TOUCH_IN(touch),
		.LED_OUT(led), .LED_OE_N(oe_n));
	lbs_touch_model i_lbs_touch_model (.clk(clk), .rst(rst), .press(press), .touch(touch));

	// one apb transfer; the request holds until pready is seen high at an edge
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clk);
		apb.penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		apb <= '0;
		@(posedge clk);
	endtask : xfer

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rchk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// counts pin changes; a steady level gives zero, pwm gives many
	task automatic tog(input int ch, input int n);
		logic p;
		tg = 0;
		p = led[ch];
		repeat (n) begin
			@(posedge clk);
			if (led[ch] !== p) tg++;
			p = led[ch];
		end
	endtask : tog

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	// watchdog: the sequence needs about 15300 cycles
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(12'h254, 32'h005D_1420);
		rchk(SELA, 32'h0);
		rchk(SELB, 32'h0);
		rchk(SELC, 32'h0);
		xfer(1'b1, SELA, 32'hFFFF_FFE4);
		rchk(SELA, 32'hE4);
		xfer(1'b1, SELB, 32'h1B);
		rchk(SELB, 32'h1B);
		xfer(1'b1, SELC, 32'hC9);
		rchk(SELC, 32'hC9);
		xfer(1'b0, 12'h400, 32'h0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		// working modes: ch4 pulse one, ch5 pulse two, ch6 breathe, ch11 awake breathe
		xfer(1'b1, SELA, 32'h40);
		xfer(1'b1, SELB, 32'h0E);
		xfer(1'b1, SELC, 32'h30);
		xfer(1'b1, CFG, 32'h0);
		xfer(1'b1, 12'h254, 32'h0);
		// direct through the drive bit, both polarities
		xfer(1'b1, DRV, 32'h1);
		cyc(3);
		`CHK(led[0], 1'b1)
		`CHK(oe_n[0], 1'b0)
		xfer(1'b1, DRV, 32'h0);
		cyc(3);
		`CHK(led[0], 1'b0)
		xfer(1'b1, POL, 32'h1);
		cyc(3);
		`CHK(led[0], 1'b1)
		xfer(1'b1, DRV, 32'h1);
		cyc(3);
		`CHK(led[0], 1'b0)
		xfer(1'b1, DRV, 32'h0);
		xfer(1'b1, POL, 32'h0);
		// a pin set as input ignores its behaviour
		xfer(1'b1, DIR, 32'h1);
		xfer(1'b1, DRV, 32'h1);
		cyc(3);
		`CHK(led[0], 1'b0)
		`CHK(oe_n[0], 1'b1)
		xfer(1'b1, DRV, 32'h0);
		xfer(1'b1, DIR, 32'h0);
		// linked channel follows the sensor
		xfer(1'b1, LNK, 32'h2);
		press <= 11'h002;
		cyc(4);
		`CHK(led[1], 1'b1)
		press <= 11'h000;
		cyc(4);
		`CHK(led[1], 1'b0)
		// link switch onto an idle sensor acts as a release
		xfer(1'b1, DRV, 32'h4);
		cyc(3);
		`CHK(led[2], 1'b1)
		xfer(1'b1, LNK, 32'h6);
		cyc(3);
		`CHK(led[2], 1'b0)
		press <= 11'h004;
		cyc(4);
		`CHK(led[2], 1'b1)
		press <= 11'h000;
		xfer(1'b1, DRV, 32'h0);
		xfer(1'b1, LNK, 32'h300);
		// group channels never both active
		press <= 11'h100;
		cyc(4);
		rchk(STAT, 32'h0100_0100);
		press <= 11'h300;
		cyc(4);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[9:8], 2'b10)
		press <= 11'h000;
		cyc(4);
		// pulse one: a clear-and-set mid pulse is not remembered
		xfer(1'b1, DRV, 32'h8);
		cyc(300);
		xfer(1'b1, DRV, 32'h0);
		xfer(1'b1, DRV, 32'h8);
		cyc(300);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[3], 1'b1)
		cyc(700);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[3], 1'b0)
		`CHK(led[3], 1'b0)
		// count field one gives two pulses
		xfer(1'b1, CFG, 32'h10);
		xfer(1'b1, DRV, 32'h0);
		xfer(1'b1, DRV, 32'h8);
		cyc(1500);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[3], 1'b1)
		cyc(800);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[3], 1'b0)
		// edge select: start on clear, not on set
		xfer(1'b1, CFG, 32'h8);
		xfer(1'b1, DRV, 32'h0);
		cyc(100);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[3], 1'b1)
		cyc(1100);
		xfer(1'b1, DRV, 32'h8);
		cyc(100);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[3], 1'b0)
		xfer(1'b1, CFG, 32'h0);
		// pulse two: runs on, then one tail pulse, then minimum
		xfer(1'b1, DRV, 32'h10);
		cyc(2500);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[4], 1'b1)
		xfer(1'b1, DRV, 32'h0);
		cyc(400);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[4], 1'b1)
		cyc(2200);
		xfer(1'b0, STAT, 32'h0);
		`CHK(rd[4], 1'b0)
		`CHK(led[4], 1'b0)
		// breathe ramps, stops on clear
		xfer(1'b1, DRV, 32'h20);
		tog(5, 1500);
		`CHK(tg > 4, 1'b1)
		xfer(1'b1, DRV, 32'h0);
		cyc(6);
		`CHK(led[5], 1'b0)
		// ch11: sleep field (direct) while asleep, awake field (breathe) otherwise
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, CFG, (k == 0) ? 32'h3 : 32'h5);
			xfer(1'b1, DRV, 32'h400);
			cyc(5);
			tog(10, 1000);
			`CHK(tg, 0)
			`CHK(led[10], 1'b1)
			xfer(1'b1, DRV, 32'h0);
			cyc(5);
		end
		xfer(1'b1, CFG, 32'h0);
		xfer(1'b1, DRV, 32'h400);
		tog(10, 1500);
		`CHK(tg > 4, 1'b1)
		xfer(1'b1, DRV, 32'h0);
		conclude();
	end
endmodule : lbs_top_bench

`default_nettype wire
